/* File: logic/mscall_pkg.sv */
// shared constants and types for the modem call-timing register bank
package mscall_pkg;
  // command port
  localparam int unsigned REG_CNT = 12;
  localparam int unsigned IDX_W   = 4;

  // register indices as used by the query and set commands
  localparam logic [3:0] REG_ANSWER  = 4'h0;
  localparam logic [3:0] REG_RING    = 4'h1;
  localparam logic [3:0] REG_ESCAPE  = 4'h2;
  localparam logic [3:0] REG_TERM    = 4'h3;
  localparam logic [3:0] REG_LF      = 4'h4;
  localparam logic [3:0] REG_ERASE   = 4'h5;
  localparam logic [3:0] REG_DT_WAIT = 4'h6;
  localparam logic [3:0] REG_CW_WAIT = 4'h7;
  localparam logic [3:0] REG_COMMA   = 4'h8;
  localparam logic [3:0] REG_QUAL    = 4'h9;
  localparam logic [3:0] REG_LOSS    = 4'hA;
  localparam logic [3:0] REG_TONE    = 4'hB;
  localparam logic [3:0] REG_LAST    = 4'hB;

  // reset contents, indexed as above
  localparam logic [7:0] REG_RESET [0:11] = '{
    8'h00, 8'h00, 8'h2B, 8'h0D, 8'h0A, 8'h08,
    8'h02, 8'h1E, 8'h02, 8'h06, 8'h0E, 8'h46
  };

  // accepted value ranges
  localparam logic [7:0] ERASE_MAX   = 8'h20;
  localparam logic [7:0] TIMED_MIN   = 8'h01;
  localparam logic [7:0] TONE_MIN    = 8'h32;
  localparam logic [7:0] RING_MAX    = 8'hFF;
  localparam logic [7:0] DT_MIN_SECS = 8'h02;
  localparam int unsigned ESC_DIS_BIT = 7;

  // timing
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * TICK_US;
  localparam logic [6:0]  MS_PER_TENTH   = 7'h64;
  localparam logic [3:0]  TENTH_PER_SEC  = 4'hA;
  localparam logic [3:0]  RING_IDLE_SECS = 4'h8;
  localparam logic [1:0]  ESC_REPEAT     = 2'h3;
  localparam logic [9:0]  ESC_WINDOW_MS  = 10'h3E8;
  localparam logic [9:0]  PULSE_BREAK_MS = 10'h03D;
  localparam logic [9:0]  PULSE_MAKE_MS  = 10'h027;
  localparam logic [9:0]  PULSE_IDD_MS   = 10'h311;
  localparam logic [3:0]  PULSE_ZERO_CNT = 4'hA;

  typedef enum logic [2:0] {
    MSCALL_IDLE    = 3'b000,
    MSCALL_DT_WAIT = 3'b001,
    MSCALL_DIAL    = 3'b011,
    MSCALL_CW_WAIT = 3'b010,
    MSCALL_ONLINE  = 3'b110
  } mscall_state_e;

  typedef enum logic [2:0] {
    MSCALL_D_READY = 3'b000,
    MSCALL_D_TONE  = 3'b001,
    MSCALL_D_GAP   = 3'b011,
    MSCALL_D_BREAK = 3'b100,
    MSCALL_D_MAKE  = 3'b101,
    MSCALL_D_IDD   = 3'b111,
    MSCALL_D_COMMA = 3'b010
  } mscall_dial_e;
endpackage

/* File: logic/mscall_tick.sv */
// millisecond, tenth-second and second enable pulses from the controller clock
`timescale 1ns/1ps
module mscall_tick #(
  parameter int unsigned MS_CYCLES = mscall_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // enables
  output logic      ms_tick_o,
  output logic      tenth_tick_o,
  output logic      sec_tick_o
);
  import mscall_pkg::*;

  logic [14:0] cyc_reg;
  logic [6:0]  ms_reg;
  logic [3:0]  tenth_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_reg      <= 15'h0000;
      ms_reg       <= 7'h00;
      tenth_reg    <= 4'h0;
      ms_tick_o    <= 1'b0;
      tenth_tick_o <= 1'b0;
      sec_tick_o   <= 1'b0;
    end else begin
      ms_tick_o    <= 1'b0;
      tenth_tick_o <= 1'b0;
      sec_tick_o   <= 1'b0;
      if (cyc_reg == 15'(MS_CYCLES - 1)) begin
        cyc_reg   <= 15'h0000;
        ms_tick_o <= 1'b1;
        if (ms_reg == MS_PER_TENTH - 7'h01) begin
          ms_reg       <= 7'h00;
          tenth_tick_o <= 1'b1;
          if (tenth_reg == TENTH_PER_SEC - 4'h1) begin
            tenth_reg  <= 4'h0;
            sec_tick_o <= 1'b1;
          end else begin
            tenth_reg <= tenth_reg + 4'h1;
          end
        end else begin
          ms_reg <= ms_reg + 7'h01;
        end
      end else begin
        cyc_reg <= cyc_reg + 15'h0001;
      end
    end
  end
endmodule

/* File: logic/mscall_regs.sv */
// modem configuration register bank with ring, escape, dial and carrier timing
//
// Overview of operation
// - a query command returns the addressed register contents.
// - a set command stores the new value in the addressed register.
// - threshold 1..255 makes the modem answer when ring count reaches it.
// - threshold zero disables automatic answer entirely.
// - the answer threshold is kept in non-volatile storage.
// - read-only ring counter counts detected rings, 0 to 255.
// - ring counter clears after 8 seconds without a ring.
// - escape register 0..127 selects the escape character.
// - escape register 128..255 disables escape recognition.
// - three escape characters within one second return to command mode.
// - terminator register ends command lines and appears in responses.
// - line-feed register gives the line feed used in responses.
// - erase register accepts only values 0 to 32.
// - wait dial-tone register seconds before dialing, at least two seconds.
// - after dialing wait carrier-wait register seconds for valid carrier.
// - each comma pauses dialing for comma register seconds.
// - carrier valid after present for qualify register tenths of a second.
// - disconnect after carrier absent for loss register tenths of a second.
// - loss value below qualify value suppresses automatic disconnect.
// - tone register sets tone length and gap in milliseconds.
// - pulse dialing timing does not depend on the tone register.
`timescale 1ns/1ps
module mscall_regs #(
  parameter int unsigned MS_CYCLES = mscall_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // register command port
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [3:0] cmd_index_i,
  input  wire logic [7:0] cmd_value_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_value_o,
  output logic            rsp_error_o,
  // non-volatile store of the answer threshold
  input  wire logic [7:0] nv_answer_i,
  output logic            nv_we_o,
  output logic [7:0]      nv_data_o,
  // line events
  input  wire logic       ring_i,
  input  wire logic       carrier_i,
  input  wire logic       call_start_i,
  input  wire logic       hangup_i,
  input  wire logic       resume_i,
  output logic            off_hook_o,
  output logic            carrier_valid_o,
  output logic            no_carrier_o,
  // dial string items
  input  wire logic       dial_valid_i,
  input  wire logic       dial_comma_i,
  input  wire logic       dial_pulse_i,
  input  wire logic [3:0] dial_digit_i,
  input  wire logic       dial_last_i,
  output logic            dial_ready_o,
  output logic            tone_on_o,
  output logic [3:0]      tone_digit_o,
  output logic            pulse_break_o,
  // serial data stream and character settings
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_char_i,
  output logic            data_mode_o,
  output logic            escape_o,
  output logic [7:0]      term_char_o,
  output logic [7:0]      lf_char_o,
  output logic [7:0]      erase_char_o
);
  import mscall_pkg::*;

  logic [1:0]    rst_sync_reg;
  logic          rst_n;
  logic          ms_tick;
  logic          tenth_tick;
  logic          sec_tick;
  logic [7:0]    sreg [0:11];
  logic          nv_loaded_reg;
  logic          idx_ok;
  logic          wr_ok;
  logic          wr_en;
  logic [7:0]    ring_next;
  logic [3:0]    ring_idle_reg;
  logic          answer_hit;
  mscall_state_e state_reg;
  logic [7:0]    sec_cnt_reg;
  logic [7:0]    dt_secs;
  logic          dial_done_reg;
  mscall_dial_e  dphase_reg;
  logic [9:0]    dms_reg;
  logic [7:0]    dsec_reg;
  logic [3:0]    pulses_reg;
  logic          dlast_reg;
  logic [7:0]    qual_reg;
  logic [7:0]    loss_reg;
  logic          loss_disc_reg;
  logic          in_call;
  logic [1:0]    esc_cnt_reg;
  logic [9:0]    esc_ms_reg;
  logic          esc_match;

  // reset is released through two flops so every flop leaves reset on one edge
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  mscall_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n),
    .ms_tick_o    (ms_tick),
    .tenth_tick_o (tenth_tick),
    .sec_tick_o   (sec_tick)
  );

  // write range checks; a refused value leaves the register untouched
  always_comb begin
    idx_ok = (cmd_index_i <= REG_LAST);
    case (cmd_index_i)
      REG_RING:  wr_ok = 1'b0;
      REG_ERASE: wr_ok = (cmd_value_i <= ERASE_MAX);
      REG_CW_WAIT, REG_COMMA, REG_QUAL, REG_LOSS: wr_ok = (cmd_value_i >= TIMED_MIN);
      REG_TONE:  wr_ok = (cmd_value_i >= TONE_MIN);
      default:   wr_ok = idx_ok;
    endcase
  end
  assign wr_en = cmd_valid_i & cmd_write_i & idx_ok & wr_ok;

  // ring counter next value: a ring in the clearing cycle still counts
  always_comb begin
    ring_next = sreg[REG_RING];
    if (ring_i) begin
      if (sreg[REG_RING] != RING_MAX) begin
        ring_next = sreg[REG_RING] + 8'h01;
      end
    end else if (ring_idle_reg == RING_IDLE_SECS) begin
      ring_next = 8'h00;
    end
  end
  assign answer_hit = ring_i && (sreg[REG_ANSWER] != 8'h00)
                      && (ring_next == sreg[REG_ANSWER]);

  genvar g;
  generate
    for (g = 0; g < REG_CNT; g = g + 1) begin : g_sreg
      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          sreg[g] <= REG_RESET[g];
        end else if (g == REG_RING) begin
          sreg[g] <= ring_next;
        end else if (g == REG_ANSWER && !nv_loaded_reg) begin
          sreg[g] <= nv_answer_i;
        end else if (wr_en && cmd_index_i == 4'(g)) begin
          sreg[g] <= cmd_value_i;
        end
      end
    end
  endgenerate

  // command answers and non-volatile write-through
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      nv_loaded_reg <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_value_o   <= 8'h00;
      rsp_error_o   <= 1'b0;
      nv_we_o       <= 1'b0;
      nv_data_o     <= 8'h00;
    end else begin
      nv_loaded_reg <= 1'b1;
      rsp_valid_o   <= cmd_valid_i;
      nv_we_o       <= wr_en && (cmd_index_i == REG_ANSWER);
      if (wr_en && cmd_index_i == REG_ANSWER) begin
        nv_data_o <= cmd_value_i;
      end
      if (cmd_valid_i) begin
        if (cmd_write_i) begin
          rsp_value_o <= wr_en ? cmd_value_i : (idx_ok ? sreg[cmd_index_i] : 8'h00);
          rsp_error_o <= !wr_en;
        end else begin
          rsp_value_o <= idx_ok ? sreg[cmd_index_i] : 8'h00;
          rsp_error_o <= !idx_ok;
        end
      end
    end
  end

  // seconds since the last ring, cleared once the clear point is reached
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ring_idle_reg <= 4'h0;
    end else if (ring_i || ring_idle_reg == RING_IDLE_SECS) begin
      ring_idle_reg <= 4'h0;
    end else if (sec_tick && sreg[REG_RING] != 8'h00) begin
      ring_idle_reg <= ring_idle_reg + 4'h1;
    end
  end

  // call progress
  assign dt_secs = (sreg[REG_DT_WAIT] < DT_MIN_SECS) ? DT_MIN_SECS : sreg[REG_DT_WAIT];
  assign in_call = (state_reg == MSCALL_CW_WAIT) || (state_reg == MSCALL_ONLINE);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= MSCALL_IDLE;
      sec_cnt_reg  <= 8'h00;
      off_hook_o   <= 1'b0;
      no_carrier_o <= 1'b0;
      data_mode_o  <= 1'b0;
    end else begin
      no_carrier_o <= 1'b0;
      if (sec_tick && sec_cnt_reg != RING_MAX) begin
        sec_cnt_reg <= sec_cnt_reg + 8'h01;
      end
      if (hangup_i) begin
        state_reg   <= MSCALL_IDLE;
        off_hook_o  <= 1'b0;
        data_mode_o <= 1'b0;
      end else begin
        case (state_reg)
          MSCALL_IDLE: begin
            sec_cnt_reg <= 8'h00;
            if (answer_hit) begin
              state_reg  <= MSCALL_CW_WAIT;
              off_hook_o <= 1'b1;
            end else if (call_start_i) begin
              state_reg  <= MSCALL_DT_WAIT;
              off_hook_o <= 1'b1;
            end
          end
          MSCALL_DT_WAIT: begin
            if (sec_cnt_reg >= dt_secs) begin
              state_reg <= MSCALL_DIAL;
            end
          end
          MSCALL_DIAL: begin
            sec_cnt_reg <= 8'h00;
            if (dial_done_reg) begin
              state_reg <= MSCALL_CW_WAIT;
            end
          end
          MSCALL_CW_WAIT: begin
            if (carrier_valid_o) begin
              state_reg   <= MSCALL_ONLINE;
              data_mode_o <= 1'b1;
            end else if (sec_cnt_reg >= sreg[REG_CW_WAIT]) begin
              state_reg    <= MSCALL_IDLE;
              off_hook_o   <= 1'b0;
              no_carrier_o <= 1'b1;
            end
          end
          MSCALL_ONLINE: begin
            if (loss_disc_reg) begin
              state_reg    <= MSCALL_IDLE;
              off_hook_o   <= 1'b0;
              no_carrier_o <= 1'b1;
              data_mode_o  <= 1'b0;
            end else if (escape_o) begin
              data_mode_o <= 1'b0;
            end else if (resume_i) begin
              data_mode_o <= 1'b1;
            end
          end
          default: begin
            state_reg  <= MSCALL_IDLE;
            off_hook_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // dial string engine; one item is taken per ready/valid handshake
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dphase_reg    <= MSCALL_D_READY;
      dms_reg       <= 10'h000;
      dsec_reg      <= 8'h00;
      pulses_reg    <= 4'h0;
      dlast_reg     <= 1'b0;
      dial_done_reg <= 1'b0;
      dial_ready_o  <= 1'b0;
      tone_on_o     <= 1'b0;
      tone_digit_o  <= 4'h0;
      pulse_break_o <= 1'b0;
    end else if (state_reg != MSCALL_DIAL) begin
      dphase_reg    <= MSCALL_D_READY;
      dlast_reg     <= 1'b0;
      dial_done_reg <= 1'b0;
      dial_ready_o  <= 1'b0;
      tone_on_o     <= 1'b0;
      pulse_break_o <= 1'b0;
    end else begin
      if (ms_tick) begin
        dms_reg <= dms_reg + 10'h001;
      end
      if (sec_tick) begin
        dsec_reg <= dsec_reg + 8'h01;
      end
      case (dphase_reg)
        MSCALL_D_READY: begin
          dms_reg  <= 10'h000;
          dsec_reg <= 8'h00;
          if (dlast_reg) begin
            dial_done_reg <= 1'b1;
            dial_ready_o  <= 1'b0;
          end else if (dial_ready_o && dial_valid_i) begin
            dial_ready_o <= 1'b0;
            dlast_reg    <= dial_last_i;
            tone_digit_o <= dial_digit_i;
            pulses_reg   <= (dial_digit_i == 4'h0) ? PULSE_ZERO_CNT : dial_digit_i;
            if (dial_comma_i) begin
              dphase_reg <= MSCALL_D_COMMA;
            end else if (dial_pulse_i) begin
              dphase_reg    <= MSCALL_D_BREAK;
              pulse_break_o <= 1'b1;
            end else begin
              dphase_reg <= MSCALL_D_TONE;
              tone_on_o  <= 1'b1;
            end
          end else begin
            dial_ready_o <= 1'b1;
          end
        end
        MSCALL_D_TONE: begin
          if (dms_reg >= {2'b00, sreg[REG_TONE]}) begin
            dphase_reg <= MSCALL_D_GAP;
            tone_on_o  <= 1'b0;
            dms_reg    <= 10'h000;
          end
        end
        MSCALL_D_GAP: begin
          if (dms_reg >= {2'b00, sreg[REG_TONE]}) begin
            dphase_reg <= MSCALL_D_READY;
          end
        end
        // pulse timing uses fixed constants only, never the tone setting
        MSCALL_D_BREAK: begin
          if (dms_reg >= PULSE_BREAK_MS) begin
            dphase_reg    <= MSCALL_D_MAKE;
            pulse_break_o <= 1'b0;
            dms_reg       <= 10'h000;
            pulses_reg    <= pulses_reg - 4'h1;
          end
        end
        MSCALL_D_MAKE: begin
          if (dms_reg >= PULSE_MAKE_MS) begin
            dms_reg <= 10'h000;
            if (pulses_reg == 4'h0) begin
              dphase_reg <= MSCALL_D_IDD;
            end else begin
              dphase_reg    <= MSCALL_D_BREAK;
              pulse_break_o <= 1'b1;
            end
          end
        end
        MSCALL_D_IDD: begin
          if (dms_reg >= PULSE_IDD_MS) begin
            dphase_reg <= MSCALL_D_READY;
          end
        end
        MSCALL_D_COMMA: begin
          if (dsec_reg >= sreg[REG_COMMA]) begin
            dphase_reg <= MSCALL_D_READY;
          end
        end
        default: begin
          dphase_reg <= MSCALL_D_READY;
        end
      endcase
    end
  end

  // carrier qualification and loss, counted in tenths of a second
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      qual_reg        <= 8'h00;
      loss_reg        <= 8'h00;
      carrier_valid_o <= 1'b0;
      loss_disc_reg   <= 1'b0;
    end else if (!in_call) begin
      qual_reg        <= 8'h00;
      loss_reg        <= 8'h00;
      carrier_valid_o <= 1'b0;
      loss_disc_reg   <= 1'b0;
    end else if (carrier_i) begin
      loss_reg      <= 8'h00;
      loss_disc_reg <= 1'b0;
      if (qual_reg >= sreg[REG_QUAL]) begin
        carrier_valid_o <= 1'b1;
      end else if (tenth_tick) begin
        qual_reg <= qual_reg + 8'h01;
      end
    end else begin
      qual_reg <= 8'h00;
      if (carrier_valid_o) begin
        if (loss_reg >= sreg[REG_LOSS]) begin
          carrier_valid_o <= 1'b0;
          loss_disc_reg   <= (sreg[REG_LOSS] >= sreg[REG_QUAL]);
        end else if (tenth_tick) begin
          loss_reg <= loss_reg + 8'h01;
        end
      end
    end
  end

  // escape sequence detection in data mode
  assign esc_match = rx_valid_i && !sreg[REG_ESCAPE][ESC_DIS_BIT]
                     && (rx_char_i == {1'b0, sreg[REG_ESCAPE][6:0]});

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      esc_cnt_reg <= 2'h0;
      esc_ms_reg  <= 10'h000;
      escape_o    <= 1'b0;
    end else begin
      escape_o <= 1'b0;
      if (ms_tick && esc_cnt_reg != 2'h0 && esc_ms_reg != ESC_WINDOW_MS) begin
        esc_ms_reg <= esc_ms_reg + 10'h001;
      end
      if (!data_mode_o) begin
        esc_cnt_reg <= 2'h0;
      end else if (esc_match) begin
        // a late character starts a fresh sequence instead of being dropped
        if (esc_cnt_reg == 2'h0 || esc_ms_reg == ESC_WINDOW_MS) begin
          esc_cnt_reg <= 2'h1;
          esc_ms_reg  <= 10'h000;
        end else if (esc_cnt_reg == ESC_REPEAT - 2'h1) begin
          esc_cnt_reg <= 2'h0;
          escape_o    <= 1'b1;
        end else begin
          esc_cnt_reg <= esc_cnt_reg + 2'h1;
        end
      end else if (rx_valid_i) begin
        esc_cnt_reg <= 2'h0;
      end
    end
  end

  // character settings for the command parser and response formatter
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      term_char_o  <= REG_RESET[REG_TERM];
      lf_char_o    <= REG_RESET[REG_LF];
      erase_char_o <= REG_RESET[REG_ERASE];
    end else begin
      term_char_o  <= sreg[REG_TERM];
      lf_char_o    <= sreg[REG_LF];
      erase_char_o <= sreg[REG_ERASE];
    end
  end
endmodule

/* File: sim/mscall_regs_properties.sv */
// checker for the command port, threshold store and escape outputs
`timescale 1ns/1ps
module mscall_regs_properties
  import mscall_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_write_i,
  input wire logic [3:0] cmd_index_i,
  input wire logic [7:0] cmd_value_i,
  input wire logic       rsp_valid_o,
  input wire logic       rsp_error_o,
  input wire logic       nv_we_o,
  input wire logic       escape_o,
  input wire logic       data_mode_o,
  input wire logic [7:0] term_char_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  logic wr;
  assign wr = cmd_valid_i && cmd_write_i;
  a_rsp_one_later: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("no answer one cycle after a command");
  a_rsp_no_cause: assert property (!cmd_valid_i |=> !rsp_valid_o)
    else $error("answer without a command");
  a_ring_wr_err: assert property (wr && cmd_index_i == REG_RING |=> rsp_error_o)
    else $error("ring counter write not refused");
  a_erase_range: assert property (wr && cmd_index_i == REG_ERASE && cmd_value_i > ERASE_MAX
    |=> rsp_error_o)
    else $error("erase value above range accepted");
  a_tone_range: assert property (wr && cmd_index_i == REG_TONE && cmd_value_i < TONE_MIN
    |=> rsp_error_o)
    else $error("tone value below range accepted");
  a_wait_nonzero: assert property (wr && cmd_index_i inside {[REG_CW_WAIT:REG_LOSS]}
    && cmd_value_i == 8'h00 |=> rsp_error_o)
    else $error("zero time value accepted");
  a_term_update: assert property (wr && cmd_index_i == REG_TERM
    |=> ##1 term_char_o == $past(cmd_value_i, 2))
    else $error("terminator copy not updated");
  a_nv_follow: assert property (wr && cmd_index_i == REG_ANSWER |-> ##[1:2] nv_we_o)
    else $error("threshold write not stored");
  a_esc_leave: assert property (escape_o |=> !data_mode_o)
    else $error("data mode kept after escape");
endmodule
bind mscall_regs mscall_regs_properties u_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_index_i(cmd_index_i),
  .cmd_value_i(cmd_value_i), .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o),
  .nv_we_o(nv_we_o), .escape_o(escape_o), .data_mode_o(data_mode_o),
  .term_char_o(term_char_o));

/* File: sim/mscall_host.sv */
// host model: command driver and non-volatile threshold store
`timescale 1ns/1ps
module mscall_host (
  // clock
  input  wire logic       mclk_i,
  // command port
  output logic            cmd_valid_o,
  output logic            cmd_write_o,
  output logic [3:0]      cmd_index_o,
  output logic [7:0]      cmd_value_o,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_value_i,
  input  wire logic       rsp_error_i,
  // non-volatile store
  input  wire logic       nv_we_i,
  input  wire logic [7:0] nv_data_i,
  output logic [7:0]      nv_answer_o
);
  // the store is not reset, so it outlives the bench reset like a power loss
  logic [7:0] nv_reg = 8'h03;
  assign nv_answer_o = nv_reg;
  always @(posedge mclk_i) if (nv_we_i) nv_reg <= nv_data_i;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_index_o = 4'h0;
    cmd_value_o = 8'h00;
  end
  // a missing answer reads as EE so the caller sees a mismatch
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [7:0] v, output logic e);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_index_o <= i;
    cmd_value_o <= d;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_value_o <= ~d;
    #1;
    v = rsp_valid_i ? rsp_value_i : 8'hEE;
    e = rsp_error_i;
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the call-timing register bank
`timescale 1ns/1ps
module tb;
  import mscall_pkg::*;
  logic mclk_i = 1'b0, resetn_i = 1'b0, rsp_valid_o, rsp_error_o, nv_we_o, cv, cw, ring_i = 0;
  logic carrier_i = 0, call_start_i = 0, hangup_i = 0, resume_i = 0, off_hook_o;
  logic carrier_valid_o, no_carrier_o, dial_ready_o, tone_on_o, pulse_break_o;
  logic rx_valid_i = 0, data_mode_o, escape_o, e, dv = 0;
  logic [3:0] ci, tone_digit_o, dd = 4'h0;
  logic [7:0] cd, rsp_value_o, nv_answer_i, nv_data_o, rx_char_i = 0, v;
  logic [7:0] term_char_o, lf_char_o, erase_char_o;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #25 mclk_i = ~mclk_i;
  mscall_regs #(.MS_CYCLES(4)) u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_index_i(ci), .cmd_value_i(cd),
    .rsp_valid_o(rsp_valid_o), .rsp_value_o(rsp_value_o), .rsp_error_o(rsp_error_o),
    .nv_answer_i(nv_answer_i), .nv_we_o(nv_we_o), .nv_data_o(nv_data_o),
    .ring_i(ring_i), .carrier_i(carrier_i), .call_start_i(call_start_i),
    .hangup_i(hangup_i), .resume_i(resume_i), .off_hook_o(off_hook_o),
    .carrier_valid_o(carrier_valid_o), .no_carrier_o(no_carrier_o),
    .dial_valid_i(dv), .dial_comma_i(1'b0), .dial_pulse_i(1'b0), .dial_digit_i(dd),
    .dial_last_i(1'b1), .dial_ready_o(dial_ready_o), .tone_on_o(tone_on_o),
    .tone_digit_o(tone_digit_o), .pulse_break_o(pulse_break_o), .rx_valid_i(rx_valid_i),
    .rx_char_i(rx_char_i), .data_mode_o(data_mode_o), .escape_o(escape_o),
    .term_char_o(term_char_o), .lf_char_o(lf_char_o), .erase_char_o(erase_char_o));
  mscall_host u_host (.mclk_i(mclk_i), .cmd_valid_o(cv), .cmd_write_o(cw),
    .cmd_index_o(ci), .cmd_value_o(cd), .rsp_valid_i(rsp_valid_o),
    .rsp_value_i(rsp_value_o), .rsp_error_i(rsp_error_o), .nv_we_i(nv_we_o),
    .nv_data_i(nv_data_o), .nv_answer_o(nv_answer_i));
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ceiling covers the 9 s ring idle wait plus the answered call
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic xe);
    u_host.xfer(1'b1, i, d, v, e);
    chk({7'h00, e}, {7'h00, xe});
  endtask
  task automatic q(input logic [3:0] i, input logic [7:0] x);
    u_host.xfer(1'b0, i, 8'h00, v, e);
    chk(v, x);
  endtask
  task automatic rings(input int n);
    repeat (n) begin
      @(posedge mclk_i) ring_i <= 1'b1;
      @(posedge mclk_i) ring_i <= 1'b0;
    end
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic t_reset_vals();
    q(REG_ANSWER, 8'h03);
    for (int i = 1; i < 12; i++) q(i[3:0], REG_RESET[i]);
  endtask
  task automatic t_writes();
    wr(REG_TERM, 8'h21, 1'b0);
    q(REG_TERM, 8'h21);
    chk(term_char_o, 8'h21);
    wr(REG_LF, 8'h0C, 1'b0);
    @(posedge mclk_i) #1 chk(lf_char_o, 8'h0C);
    wr(REG_ERASE, 8'h21, 1'b1);
    wr(REG_ERASE, 8'h20, 1'b0);
    q(REG_ERASE, 8'h20);
    wr(REG_RING, 8'h05, 1'b1);
    q(REG_RING, 8'h00);
    wr(REG_CW_WAIT, 8'h00, 1'b1);
    wr(REG_TONE, 8'h31, 1'b1);
    wr(REG_TONE, 8'h32, 1'b0);
    wr(4'hC, 8'h01, 1'b1);
    wr(REG_DT_WAIT, 8'h00, 1'b0);
  endtask
  task automatic t_ring();
    wr(REG_ANSWER, 8'h00, 1'b0);
    rings(3);
    chk({7'h00, off_hook_o}, 8'h00);
    q(REG_RING, 8'h03);
    repeat (36000) @(posedge mclk_i);
    q(REG_RING, 8'h00);
  endtask
  task automatic t_call();
    logic s;
    s = 1'b0;
    wr(REG_ANSWER, 8'h02, 1'b0);
    rings(1);
    chk({7'h00, off_hook_o}, 8'h00);
    rings(1);
    chk({7'h00, off_hook_o}, 8'h01);
    @(posedge mclk_i) carrier_i <= 1'b1;
    repeat (1600) @(posedge mclk_i);
    chk({7'h00, carrier_valid_o}, 8'h00);
    repeat (1600) @(posedge mclk_i);
    chk({7'h00, carrier_valid_o}, 8'h01);
    chk({7'h00, data_mode_o}, 8'h01);
    repeat (3) begin
      @(posedge mclk_i) rx_valid_i <= 1'b1;
      rx_char_i <= 8'h2B;
      @(posedge mclk_i) rx_valid_i <= 1'b0;
    end
    repeat (2) begin
      #1 s = s | escape_o;
      @(posedge mclk_i);
    end
    chk({7'h00, s}, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk({7'h00, data_mode_o}, 8'h00);
    chk({7'h00, off_hook_o}, 8'h01);
  endtask
  task automatic t_dial();
    int n = 0;
    logic s = 1'b0;
    wr(REG_CW_WAIT, 8'h01, 1'b0);
    @(posedge mclk_i) hangup_i <= 1'b1;
    carrier_i <= 1'b0;
    @(posedge mclk_i) hangup_i <= 1'b0;
    call_start_i <= 1'b1;
    dv <= 1'b1;
    dd <= 4'h7;
    @(posedge mclk_i) call_start_i <= 1'b0;
    while (!tone_on_o && n < 9000) @(posedge mclk_i) n++;
    chk({7'h00, n > 3990 && n < 8010}, 8'h01);
    chk({4'h0, tone_digit_o}, 8'h07);
    dv <= 1'b0;
    n = 0;
    while (tone_on_o && n < 300) @(posedge mclk_i) n++;
    chk({7'h00, n > 195 && n < 205}, 8'h01);
    repeat (4500) @(posedge mclk_i) s = s | no_carrier_o;
    chk({7'h00, s}, 8'h01);
    chk({7'h00, off_hook_o}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_reset_vals();
    t_writes();
    t_ring();
    t_call();
    t_dial();
    report_and_stop();
  end
endmodule
